// *** rtl/mac_unit.sv ***
// multiply-accumulate unit with banked accumulator and shift register
`include "mac_unit_cfg.svh"

module mac_unit
  import mac_unit_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RESETN,
  input  wire reg_req_type REQ,
  output logic [15:0]      RDATA
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]     control;
  logic [15:0]    operand_a;
  logic [15:0]    operand_b;
  acc_type        bank [2];
  logic           bank_choice_bit;
  logic           shift_carry;
  logic [15:0]    result_upper_read;
  logic [15:0]    result_lower_read;
  load_state_type load_state;

  function automatic logic hit(input reg_req_type r, input logic [4:0] idx);
    hit = r.write && (r.index == idx);
  endfunction : hit

  // ----------------------------------------------------------------
  // operation start
  // ----------------------------------------------------------------
  logic        wr_a;
  logic        wr_b;
  logic        clr;
  logic        start;
  logic [15:0] op_a;
  logic [15:0] op_b;
  acc_type     acc_cur;

  assign wr_a    = hit(REQ, `IDX_OPERAND_A);
  assign wr_b    = hit(REQ, `IDX_OPERAND_B);
  assign clr     = hit(REQ, `IDX_CONTROL) && REQ.data[`BIT_CLEAR];
  assign acc_cur = bank[bank_choice_bit];

  always_comb begin
    start = 1'b0;
    if (wr_a || wr_b) begin
      if (control[`BIT_SQUARE] || control[`BIT_OPCOUNT]) begin
        start = 1'b1;
      end else begin
        start = (wr_a && (wr_b || load_state == LOAD_B_SEEN)) ||
                (wr_b && load_state == LOAD_A_SEEN);
      end
    end
  end

  // square loads the written word into both operands
  always_comb begin
    op_a = wr_a ? REQ.data : operand_a;
    op_b = wr_b ? REQ.data : operand_b;
    if (control[`BIT_SQUARE]) begin
      op_a = REQ.data;
      op_b = REQ.data;
    end
  end

  // ----------------------------------------------------------------
  // datapath
  // ----------------------------------------------------------------
  logic signed [33:0] product;
  logic        [47:0] prod_ext;
  logic        [47:0] acc_flat;
  logic        [47:0] result;
  logic        [48:0] wide_sum;
  logic               overflow_now;

  always_comb begin
    if (control[`BIT_UNSIGNED]) begin
      product = $signed({2'b00, 32'(op_a * op_b)});
    end else begin
      product = 34'(($signed(op_a) * $signed(op_b)));
    end
    prod_ext = {{14{product[33]}}, product};
    if (control[`BIT_NEGATE]) begin
      prod_ext = 48'(-prod_ext);
    end
    acc_flat = {acc_cur.high, acc_cur.mid, acc_cur.low};
    wide_sum = control[`BIT_ACCUM] ? {1'b0, acc_flat} + {1'b0, prod_ext} : {1'b0, prod_ext};
    result   = wide_sum[47:0];
    overflow_now = 1'b0;
    if (control[`BIT_ACCUM]) begin
      if (control[`BIT_UNSIGNED]) begin
        overflow_now = control[`BIT_NEGATE] ? ~wide_sum[48] : wide_sum[48];
      end else begin
        // sign of the sum differs from two agreeing inputs
        overflow_now = (acc_flat[47] == prod_ext[47]) &&
                       (result[47] != acc_flat[47]);
      end
    end else if (control[`BIT_NEGATE] && control[`BIT_UNSIGNED]) begin
      overflow_now = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // operand load counter
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      load_state <= LOAD_NONE;
    end else if (clr || start) begin
      load_state <= LOAD_NONE;
    end else if (wr_a) begin
      load_state <= LOAD_A_SEEN;
    end else if (wr_b) begin
      load_state <= LOAD_B_SEEN;
    end
  end

  // ----------------------------------------------------------------
  // operands
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      operand_a <= `RESET_WORD;
      operand_b <= `RESET_WORD;
    end else if (clr) begin
      operand_a <= `RESET_WORD;
      operand_b <= `RESET_WORD;
    end else if (wr_a || wr_b) begin
      operand_a <= op_a;
      operand_b <= op_b;
    end
  end

  // ----------------------------------------------------------------
  // control and overflow
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      control <= `RESET_BYTE;
    end else begin
      if (hit(REQ, `IDX_CONTROL)) begin
        control[`BIT_INHIBIT:0] <= REQ.data[`BIT_INHIBIT:0];
        control[`BIT_CLEAR]     <= 1'b0;
      end
      if (clr) begin
        control[`BIT_OVERFLOW] <= 1'b0;
      end else if (start) begin
        control[`BIT_OVERFLOW] <= overflow_now;
      end
    end
  end

  // ----------------------------------------------------------------
  // accumulator banks
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      bank_choice_bit <= 1'b0;
    end else if (hit(REQ, `IDX_BANK_SEL)) begin
      bank_choice_bit <= REQ.data[0];
    end
  end

  logic sh_left;
  logic sh_right;
  assign sh_left  = hit(REQ, `IDX_SHIFT) && REQ.data[`BIT_SHIFT_LEFT];
  assign sh_right = hit(REQ, `IDX_SHIFT) && REQ.data[`BIT_SHIFT_RIGHT];

  for (genvar g = 0; g < 2; g++) begin : g_bank
    logic sel;
    assign sel = (bank_choice_bit == 1'(g));
    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        bank[g] <= '{default: `RESET_WORD};
      end else if (sel) begin
        if (clr) begin
          bank[g] <= '{default: `RESET_WORD};
        end else if (start && !control[`BIT_INHIBIT]) begin
          bank[g] <= result;
        end else if (sh_right) begin
          bank[g] <= {acc_flat[47], acc_flat[47:1]};
        end else if (sh_left) begin
          bank[g] <= {acc_flat[46:0], 1'b0};
        end else if (hit(REQ, `IDX_ACC_HIGH)) begin
          bank[g].high <= REQ.data;
        end else if (hit(REQ, `IDX_ACC_MID)) begin
          bank[g].mid <= REQ.data;
        end else if (hit(REQ, `IDX_ACC_LOW)) begin
          bank[g].low <= REQ.data;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // shift carry
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      shift_carry <= 1'b0;
    end else if (sh_right) begin
      shift_carry <= acc_flat[0];
    end else if (sh_left) begin
      shift_carry <= acc_flat[47];
    end else if (hit(REQ, `IDX_SHIFT) && !REQ.data[`BIT_SHIFT_CARRY]) begin
      shift_carry <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // result read words
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      result_upper_read <= `RESET_WORD;
      result_lower_read <= `RESET_WORD;
    end else if (clr) begin
      result_upper_read <= `RESET_WORD;
      result_lower_read <= `RESET_WORD;
    end else if (start) begin
      result_upper_read <= result[31:16];
      result_lower_read <= result[15:0];
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      RDATA <= `RESET_WORD;
    end else if (REQ.read) begin
      unique case (REQ.index)
        `IDX_CONTROL:   RDATA <= {8'h00, control};
        `IDX_OPERAND_A: RDATA <= operand_a;
        `IDX_OPERAND_B: RDATA <= operand_b;
        `IDX_ACC_HIGH:  RDATA <= acc_cur.high;
        `IDX_ACC_MID:   RDATA <= acc_cur.mid;
        `IDX_ACC_LOW:   RDATA <= acc_cur.low;
        `IDX_SHIFT:     RDATA <= {8'h00, shift_carry, 7'h00};
        `IDX_RES_UPPER: RDATA <= result_upper_read;
        `IDX_RES_LOWER: RDATA <= result_lower_read;
        `IDX_BANK_SEL:  RDATA <= {15'h0000, bank_choice_bit};
        default:        RDATA <= `RESET_WORD;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_clear_zeroes: assert property (@(posedge CLK) disable iff (!RESETN)
    clr |=> (operand_a == 16'h0000 && operand_b == 16'h0000 && acc_flat == 48'h0))
    else $error("clear did not zero operands");
  a_right_shift: assert property (@(posedge CLK) disable iff (!RESETN)
    (sh_right && !clr && !start && !$changed(bank_choice_bit))
    |=> acc_flat == {$past(acc_flat[47]), $past(acc_flat[47:1])} && shift_carry == $past(acc_flat[0]))
    else $error("right shift wrong");
  a_left_shift: assert property (@(posedge CLK) disable iff (!RESETN)
    (sh_left && !sh_right && !clr && !start)
    |=> acc_flat == {$past(acc_flat[46:0]), 1'b0} && shift_carry == $past(acc_flat[47]))
    else $error("left shift wrong");
  a_shift_keeps_read: assert property (@(posedge CLK) disable iff (!RESETN)
    ((sh_left || sh_right) && !start && !clr) |=> $stable(result_lower_read) && $stable(result_upper_read))
    else $error("shift changed read words");
  a_inhibit_keeps: assert property (@(posedge CLK) disable iff (!RESETN)
    (start && control[`BIT_INHIBIT] && !clr) |=> $stable(acc_flat))
    else $error("inhibited write changed accumulator");
  a_read_words: assert property (@(posedge CLK) disable iff (!RESETN)
    (start && !clr) |=> {result_upper_read, result_lower_read} == $past(result[31:0]))
    else $error("read words not loaded");
  a_two_loads: assert property (@(posedge CLK) disable iff (!RESETN)
    (wr_a && !wr_b && load_state == LOAD_NONE && control[4:3] == 2'b00) |-> !start)
    else $error("single operand started operation");
  a_reserved_zero: assert property (@(posedge CLK) disable iff (!RESETN)
    (REQ.read && REQ.index == `IDX_SHIFT) |=> RDATA == {8'h00, $past(shift_carry), 7'h00})
    else $error("shift command bits read nonzero");
  c_accumulate: cover property (@(posedge CLK) start && control[`BIT_ACCUM]);
  c_square: cover property (@(posedge CLK) start && control[`BIT_SQUARE]);
  c_bank_swap: cover property (@(posedge CLK) $changed(bank_choice_bit));

endmodule : mac_unit

// *** rtl/mac_unit_cfg.svh ***
// register indices, field positions and reset values of the multiply-accumulate unit
`ifndef MAC_UNIT_CFG_SVH
`define MAC_UNIT_CFG_SVH

`define IDX_CONTROL    5'h00
`define IDX_OPERAND_A  5'h01
`define IDX_OPERAND_B  5'h02
`define IDX_ACC_HIGH   5'h03
`define IDX_ACC_MID    5'h04
`define IDX_ACC_LOW    5'h05
`define IDX_SHIFT      5'h07
`define IDX_RES_UPPER  5'h08
`define IDX_RES_LOWER  5'h09
`define IDX_BANK_SEL   5'h0e

`define BIT_UNSIGNED   0
`define BIT_ACCUM      1
`define BIT_NEGATE     2
`define BIT_OPCOUNT    3
`define BIT_SQUARE     4
`define BIT_CLEAR      5
`define BIT_INHIBIT    6
`define BIT_OVERFLOW   7

`define BIT_SHIFT_LEFT  0
`define BIT_SHIFT_RIGHT 1
`define BIT_SHIFT_CARRY 7

`define RESET_WORD     16'h0000
`define RESET_BYTE     8'h00

`endif

// *** rtl/mac_unit_pkg.sv ***
// types shared by the multiply-accumulate unit
package mac_unit_pkg;

  typedef struct packed {
    logic        write;
    logic        read;
    logic [4:0]  index;
    logic [15:0] data;
  } reg_req_type;

  typedef struct packed {
    logic [15:0] high;
    logic [15:0] mid;
    logic [15:0] low;
  } acc_type;

  typedef enum logic [1:0] {
    LOAD_NONE,
    LOAD_A_SEEN,
    LOAD_B_SEEN
  } load_state_type;

endpackage : mac_unit_pkg

// *** testbench/multiply_accumulate_unit_test.sv ***
// self-checking testbench of the multiply-accumulate unit
`include "mac_unit_cfg.svh"

module multiply_accumulate_unit_test
  import mac_unit_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        CLK;
  logic        RESETN;
  reg_req_type REQ;
  logic [15:0] RDATA;
  int          fails;
  int          num_checks;

  logic [4:0]  reset_idx [10] = '{`IDX_CONTROL, `IDX_OPERAND_A, `IDX_OPERAND_B, `IDX_ACC_HIGH,
    `IDX_ACC_MID, `IDX_ACC_LOW, `IDX_SHIFT, `IDX_RES_UPPER, `IDX_RES_LOWER, `IDX_BANK_SEL};
  logic [15:0] mac_ctrl [4] = '{16'h0003, 16'h0002, 16'h0007, 16'h0006};
  logic [15:0] mac_a    [4] = '{16'h0fff, 16'hf001, 16'h0fff, 16'hf001};
  logic [47:0] mac_exp  [4] = '{48'h0000_0200_0000, 48'h0000_0000_0002,
                                48'h0000_0000_0002, 48'h0000_0200_0000};

  mac_unit uut (
    .CLK    (CLK),
    .RESETN (RESETN),
    .REQ    (REQ),
    .RDATA  (RDATA)
  );

  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end

  // ----------------------------------------
  // register access tasks
  // ----------------------------------------
  task automatic idle(input int n);
    REQ = '0;
    repeat (n) @(posedge CLK);
    #1;
  endtask : idle

  // write strobe stays up; the next call or idle replaces it
  task automatic wr(input logic [4:0] idx, input logic [15:0] d);
    REQ = '{write: 1'b1, read: 1'b0, index: idx, data: d};
    @(posedge CLK);
    #1;
  endtask : wr

  task automatic rd(input logic [4:0] idx, input logic [15:0] exp, input string name);
    REQ = '{write: 1'b0, read: 1'b1, index: idx, data: 16'h0000};
    @(posedge CLK);
    #1;
    REQ = '0;
    @(posedge CLK);
    #1;
    num_checks++;
    if (RDATA !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, RDATA);
    end
  endtask : rd

  task automatic acc(input logic [47:0] v);
    rd(`IDX_ACC_HIGH, v[47:32], "acc high");
    rd(`IDX_ACC_MID, v[31:16], "acc mid");
    rd(`IDX_ACC_LOW, v[15:0], "acc low");
  endtask : acc

  task automatic setacc(input logic [47:0] v);
    wr(`IDX_ACC_HIGH, v[47:32]);
    wr(`IDX_ACC_MID, v[31:16]);
    wr(`IDX_ACC_LOW, v[15:0]);
  endtask : setacc

  task automatic res(input logic [31:0] v);
    rd(`IDX_RES_UPPER, v[31:16], "result upper");
    rd(`IDX_RES_LOWER, v[15:0], "result lower");
  endtask : res

  // accumulator lands one edge after the start, so wait before reading
  task automatic op(input logic [15:0] ctrl, input logic [15:0] a, input logic [15:0] b);
    wr(`IDX_CONTROL, ctrl);
    wr(`IDX_OPERAND_A, a);
    wr(`IDX_OPERAND_B, b);
    idle(2);
  endtask : op

  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    RESETN = 1'b0;
    REQ = '0;
    fails = 0;
    num_checks = 0;
    repeat (6) @(posedge CLK);
    #1;
    RESETN = 1'b1;
    foreach (reset_idx[i]) rd(reset_idx[i], 16'h0000, "reset value");
    op(16'h0021, 16'h0fff, 16'h1001);
    res(32'h00ff_ffff);
    acc(48'h0000_00ff_ffff);
    rd(`IDX_CONTROL, 16'h0001, "control");
    rd(`IDX_OPERAND_A, 16'h0fff, "operand a");
    op(16'h0020, 16'hf001, 16'h1001);
    res(32'hff00_0001);
    acc(48'hffff_ff00_0001);
    op(16'h0024, 16'hf001, 16'h1001);
    res(32'h00ff_ffff);
    for (int i = 0; i < 4; i++) begin
      setacc(48'h0000_0100_0001);
      op(mac_ctrl[i], mac_a[i], 16'h1001);
      acc(mac_exp[i]);
    end
    setacc(48'h8000_8000_0001);
    op(16'h0041, 16'h0003, 16'h0005);
    res(32'h0000_000f);
    acc(48'h8000_8000_0001);
    wr(`IDX_SHIFT, 16'h0002);
    idle(2);
    acc(48'hc000_4000_0000);
    rd(`IDX_SHIFT, 16'h0080, "shift control");
    res(32'h0000_000f);
    wr(`IDX_SHIFT, 16'h0000);
    rd(`IDX_SHIFT, 16'h0000, "shift control");
    wr(`IDX_SHIFT, 16'h0001);
    idle(2);
    acc(48'h8000_8000_0000);
    rd(`IDX_SHIFT, 16'h0080, "shift control");
    res(32'h0000_000f);
    setacc(48'h0001_0001_0002);
    wr(`IDX_SHIFT, 16'h0002);
    acc(48'h0000_8000_8001);
    rd(`IDX_SHIFT, 16'h0000, "shift control");
    wr(`IDX_SHIFT, 16'h0001);
    acc(48'h0001_0001_0002);
    rd(`IDX_SHIFT, 16'h0000, "shift control");
    wr(`IDX_CONTROL, 16'h0021);
    wr(`IDX_OPERAND_A, 16'h0003);
    idle(2);
    res(32'h0000_0000);
    wr(`IDX_OPERAND_B, 16'h0005);
    idle(2);
    res(32'h0000_000f);
    wr(`IDX_CONTROL, 16'h0009);
    wr(`IDX_OPERAND_A, 16'h0007);
    idle(2);
    res(32'h0000_0023);
    wr(`IDX_CONTROL, 16'h0031);
    wr(`IDX_OPERAND_B, 16'h0009);
    idle(2);
    res(32'h0000_0051);
    rd(`IDX_OPERAND_A, 16'h0009, "operand a");
    setacc(48'h8000_8000_0001);
    wr(`IDX_BANK_SEL, 16'h00ff);
    rd(`IDX_BANK_SEL, 16'h0001, "bank select");
    acc(48'h0000_0000_0000);
    setacc(48'h1111_2222_3333);
    wr(`IDX_BANK_SEL, 16'h0000);
    acc(48'h8000_8000_0001);
    wr(`IDX_BANK_SEL, 16'h0001);
    acc(48'h1111_2222_3333);
    idle(1);
    results();
  end

  // cuts a hang short; the sequence needs well under 2000 cycles
  initial begin
    #20000;
    fails++;
    results();
  end

endmodule : multiply_accumulate_unit_test
